// file: src/hbp_line_if.sv
// synchronised port b line levels shared between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface hbp_line_if;
  logic dp;  // d+ after two flops
  logic dm;  // d- after two flops
  modport src  (output dp, output dm);
  modport sink (input dp, input dm);
endinterface
`default_nettype wire

// file: src/hbp_line_sync.sv
// two-flop synchroniser for the d+ and d- pins
`timescale 1ns/1ps
`default_nettype none
module hbp_line_sync (
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  input  wire logic  ce_i,
  input  wire logic  dplus_pin_i,
  input  wire logic  dminus_pin_i,
  hbp_line_if.src    line
);
  logic [1:0] meta;  // first stage, read only by the second

  // both stages move only while the clock enable is high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta    <= 2'b00;
      line.dp <= 1'b0;
      line.dm <= 1'b0;
    end else if (ce_i) begin
      meta    <= {dplus_pin_i, dminus_pin_i};
      line.dp <= meta[1];
      line.dm <= meta[0];
    end
  end
endmodule
`default_nettype wire

// file: src/hbp_persist_det.sv
// persistence detector: line pattern held for a number of cycles
`timescale 1ns/1ps
`default_nettype none
module hbp_persist_det #(
  parameter int unsigned CYCLES = 313,
  parameter logic [1:0]  MATCH  = 2'b00
) (
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  input  wire logic  ce_i,
  hbp_line_if.sink   line,
  output logic       held_o
);
  localparam int unsigned CW    = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIM = CW'(CYCLES);
  logic [CW-1:0] count;  // cycles the pattern has held
  logic          match;  // pattern present now

  assign match  = ({line.dp, line.dm} == MATCH);
  assign held_o = (count == LIM);

  // count while the pattern holds, restart on any change
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (ce_i) begin
      if (!match) begin
        count <= '0;
      end else if (count != LIM) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/hbp_pkg.sv
// constants, field positions and types of the port b line control block
//
// Summary of operation
// - speed bit one means low speed
// - reset bit held drives se0 continuously
// - resume bit held drives k continuously
// - resume clear ends k, sends ls eop
// - frame enable sends frame start every 1 ms
// - frame start skipped during reset or resume
// - frame number counts every 1 ms while frame enable is set, skipped or not
// - se0 for 2.5 us sets detach flag
// - dp low dm high 2.5 us sets flag
// - dp high dm low 2.5 us sets flag
// - detection flags sticky until software clears
// - flag with enable requests detect interrupt
// - line differing from expected sets active flag
// - active flag with enable: hold release, interrupt
// - latch bits 7:6 read live pins
// - read-modify-write reads stored latch contents
// - pins readable whatever the direction
// - direction one: latch bit drives pin
// - attach: se0 expected, j sets flags
// - detach: j expected, se0 sets flags
package hbp_pkg;
  // clock rate and timing figures
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned DET_TIME_NS    = 2500;
  localparam int unsigned DET_CYCLES     = (DET_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FRAME_TIME_US  = 1000;
  localparam int unsigned FRAME_CYCLES   = FRAME_TIME_US * CLK_MHZ;
  localparam int unsigned EOP_SE0_NS     = 1330;
  localparam int unsigned EOP_SE0_CYCLES = (EOP_SE0_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EOP_J_NS       = 667;
  localparam int unsigned EOP_J_CYCLES   = (EOP_J_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  EOP_SE0_LAST   = 8'(EOP_SE0_CYCLES - 1);
  localparam logic [7:0]  EOP_J_LAST     = 8'(EOP_J_CYCLES - 1);
  // register indices and byte addresses
  localparam int unsigned ADDR_W       = 18;
  localparam logic [15:0] IDX_LATCH    = 16'hfe48;
  localparam logic [15:0] IDX_DIR      = 16'hfe49;
  localparam logic [15:0] IDX_TEST     = 16'hfec6;
  localparam logic [15:0] IDX_LINE     = 16'hfec7;
  localparam logic [15:0] IDX_EVENT    = 16'hfec8;
  localparam logic [15:0] IDX_FRAME_LO = 16'hfeca;
  localparam logic [15:0] IDX_FRAME_HI = 16'hfecb;
  localparam logic [15:0] IDX_ACTIVE   = 16'hfecc;
  localparam logic [17:0] A_LATCH      = {IDX_LATCH, 2'b00};
  localparam logic [17:0] A_DIR        = {IDX_DIR, 2'b00};
  localparam logic [17:0] A_TEST       = {IDX_TEST, 2'b00};
  localparam logic [17:0] A_LINE       = {IDX_LINE, 2'b00};
  localparam logic [17:0] A_EVENT      = {IDX_EVENT, 2'b00};
  localparam logic [17:0] A_FRAME_LO   = {IDX_FRAME_LO, 2'b00};
  localparam logic [17:0] A_FRAME_HI   = {IDX_FRAME_HI, 2'b00};
  localparam logic [17:0] A_ACTIVE     = {IDX_ACTIVE, 2'b00};
  // field positions
  localparam int unsigned LC_SPEED  = 3;
  localparam int unsigned LC_RESET  = 2;
  localparam int unsigned LC_RESUME = 1;
  localparam int unsigned LC_SOF    = 0;
  localparam int unsigned EV_DET_F  = 7;
  localparam int unsigned EV_FSR_F  = 5;
  localparam int unsigned EV_FSA_F  = 3;
  localparam int unsigned BA_FLAG   = 3;
  localparam int unsigned BA_EN     = 2;
  localparam int unsigned PIN_DP    = 7;
  localparam int unsigned PIN_DM    = 6;
  localparam int unsigned FL_DET    = 2;
  localparam int unsigned FL_FSR    = 1;
  localparam int unsigned FL_FSA    = 0;
  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [3:0]  RST_LINE  = 4'h0;
  localparam logic [3:0]  LINE_HIGH = 4'hf;
  localparam logic [15:0] RST_FRAME = 16'h0000;
  // expected line state codes and line patterns {dp, dm}
  localparam logic [1:0]  ST_SE0 = 2'b00;
  localparam logic [1:0]  ST_J   = 2'b10;
  localparam logic [1:0]  ST_K   = 2'b01;
  // host line driver states
  typedef enum logic [2:0] {
    DRV_IDLE, DRV_RESET, DRV_RESUME, DRV_EOP_SE0, DRV_EOP_J
  } hbp_drive_e;
endpackage

// file: src/hbp_port_ctrl.sv
// port b line control: apb registers, line driver, frame timer, detectors
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module hbp_port_ctrl #(
  parameter int unsigned FRAME_COUNT = hbp_pkg::FRAME_CYCLES,
  parameter int unsigned DET_COUNT   = hbp_pkg::DET_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       ce_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [hbp_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       rmw_access_i,
  input  wire logic                       dplus_pin_i,
  input  wire logic                       dminus_pin_i,
  output logic                            dplus_o,
  output logic                            dplus_oe_o,
  output logic                            dminus_o,
  output logic                            dminus_oe_o,
  output logic                            low_speed_o,
  output logic                            sof_strobe_o,
  output logic      [15:0]                frame_number_o,
  output logic                            irq_detect_o,
  output logic                            irq_bus_active_o,
  output logic                            hold_release_o
);
  import hbp_pkg::*;

  localparam int unsigned FW = $clog2(FRAME_COUNT);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_COUNT - 1);

  // synchronised line levels
  hbp_line_if line ();

  // register state
  logic [7:0]  latch;      // port data latch
  logic [7:0]  dir;        // port direction
  logic [7:0]  test_data;  // host test data
  logic [3:0]  lc;         // speed, reset, resume, frame enable
  logic [2:0]  ev_flag;    // detach, fs resume, fs attach flags
  logic [2:0]  ev_en;      // matching enables
  logic [1:0]  exp_state;  // expected line state
  logic [15:0] frame_num;  // frame number pair
  logic        ba_flag;    // bus active flag
  logic        ba_en;      // bus active enable

  // next values and helpers
  logic [2:0]  next_ev_flag;
  logic        next_ba_flag;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic [1:0]  obs_state;
  logic [2:0]  det_hit;
  logic        setup;
  logic        wr_go;
  logic [FW-1:0] frame_cnt;
  logic        frame_tick;
  hbp_drive_e  state;
  hbp_drive_e  next_state;
  logic [7:0]  eop_cnt;
  logic        host_en;
  logic        host_dp;
  logic        host_dm;

  // pin synchroniser
  hbp_line_sync u_sync (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .ce_i         (ce_i),
    .dplus_pin_i  (dplus_pin_i),
    .dminus_pin_i (dminus_pin_i),
    .line         (line)
  );

  // se0 persistence
  hbp_persist_det #(.CYCLES(DET_COUNT), .MATCH(2'b00)) u_det_se0 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .line      (line),
    .held_o    (det_hit[FL_DET])
  );

  // d+ low, d- high persistence
  hbp_persist_det #(.CYCLES(DET_COUNT), .MATCH(2'b01)) u_det_fsr (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .line      (line),
    .held_o    (det_hit[FL_FSR])
  );

  // d+ high, d- low persistence
  hbp_persist_det #(.CYCLES(DET_COUNT), .MATCH(2'b10)) u_det_fsa (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .line      (line),
    .held_o    (det_hit[FL_FSA])
  );

  // apb phases; registers sit in byte lane 0
  assign setup = psel_i && !penable_i;
  assign wr_go = psel_i && penable_i && pwrite_i && pstrb_i[0];

  // read mux and address decode
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    unique case (paddr_i)
      A_LATCH: begin
        if (rmw_access_i) begin
          rd_val = latch;
        end else begin
          rd_val = {line.dp, line.dm, latch[5:0]};
        end
      end
      A_DIR:      rd_val = dir;
      A_TEST:     rd_val = test_data;
      A_LINE:     rd_val = {LINE_HIGH, lc};
      A_EVENT: begin
        rd_val = {ev_flag[FL_DET], ev_en[FL_DET], ev_flag[FL_FSR],
                  ev_en[FL_FSR], ev_flag[FL_FSA], ev_en[FL_FSA], exp_state};
      end
      A_FRAME_LO: rd_val = frame_num[7:0];
      A_FRAME_HI: rd_val = frame_num[15:8];
      A_ACTIVE:   rd_val = {4'h0, ba_flag, ba_en, 2'b00};
      default:    rd_hit = 1'b0;  // unmapped answers with an error
    endcase
  end

  // bus answers: data and error caught in setup, zero wait states
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      pready_o  <= 1'b0;
    end else if (ce_i) begin
      pready_o <= 1'b1;
      if (setup) begin
        prdata_o  <= {24'h00_0000, rd_val};
        pslverr_o <= !rd_hit;
      end
    end
  end

  // plain software registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch     <= RST_BYTE;
      dir       <= RST_BYTE;
      test_data <= RST_BYTE;
      lc        <= RST_LINE;
      ev_en     <= 3'b000;
      exp_state <= ST_SE0;
      ba_en     <= 1'b0;
    end else if (ce_i && wr_go) begin
      if (paddr_i == A_LATCH) begin
        latch <= pwdata_i[7:0];
      end
      if (paddr_i == A_DIR) begin
        dir <= pwdata_i[7:0];
      end
      if (paddr_i == A_TEST) begin
        test_data <= pwdata_i[7:0];
      end
      if (paddr_i == A_LINE) begin
        lc <= pwdata_i[3:0];
      end
      if (paddr_i == A_EVENT) begin
        ev_en     <= {pwdata_i[EV_DET_F-1], pwdata_i[EV_FSR_F-1],
                      pwdata_i[EV_FSA_F-1]};
        exp_state <= pwdata_i[1:0];
      end
      if (paddr_i == A_ACTIVE) begin
        ba_en <= pwdata_i[BA_EN];
      end
    end
  end

  // observed state in the expected-field coding; low speed swaps j and k
  assign obs_state = lc[LC_SPEED] ? {line.dm, line.dp} : {line.dp, line.dm};

  // flag updates: write zero clears, a detection in the same cycle wins
  always_comb begin
    next_ev_flag = ev_flag;
    next_ba_flag = ba_flag;
    if (wr_go && paddr_i == A_EVENT) begin
      next_ev_flag = ev_flag & {pwdata_i[EV_DET_F], pwdata_i[EV_FSR_F],
                                pwdata_i[EV_FSA_F]};
    end
    if (wr_go && paddr_i == A_ACTIVE) begin
      next_ba_flag = ba_flag & pwdata_i[BA_FLAG];
    end
    next_ev_flag = next_ev_flag | det_hit;
    if (obs_state != exp_state) begin
      next_ba_flag = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_flag <= 3'b000;
      ba_flag <= 1'b0;
    end else if (ce_i) begin
      ev_flag <= next_ev_flag;
      ba_flag <= next_ba_flag;
    end
  end

  // interrupt and hold release requests
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_detect_o     <= 1'b0;
      irq_bus_active_o <= 1'b0;
      hold_release_o   <= 1'b0;
    end else if (ce_i) begin
      irq_detect_o     <= |(ev_flag & ev_en);
      irq_bus_active_o <= ba_flag && ba_en;
      hold_release_o   <= ba_flag && ba_en;
    end
  end

  // frame timer runs only while frame starts are enabled
  assign frame_tick = lc[LC_SOF] && (frame_cnt == FRAME_LAST);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_cnt <= '0;
    end else if (ce_i) begin
      if (!lc[LC_SOF] || frame_tick) begin
        frame_cnt <= '0;
      end else begin
        frame_cnt <= frame_cnt + 1'b1;
      end
    end
  end

  // frame number: software write wins over the count
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_num <= RST_FRAME;
    end else if (ce_i) begin
      if (wr_go && paddr_i == A_FRAME_LO) begin
        frame_num[7:0] <= pwdata_i[7:0];
      end else if (wr_go && paddr_i == A_FRAME_HI) begin
        frame_num[15:8] <= pwdata_i[7:0];
      end else if (frame_tick) begin
        frame_num <= frame_num + 16'h0001;
      end
    end
  end

  // line driver sequence
  always_comb begin
    next_state = state;
    unique case (state)
      DRV_IDLE: begin
        if (lc[LC_RESET]) begin
          next_state = DRV_RESET;
        end else if (lc[LC_RESUME]) begin
          next_state = DRV_RESUME;
        end
      end
      DRV_RESET: begin
        if (!lc[LC_RESET]) begin
          next_state = DRV_IDLE;
        end
      end
      DRV_RESUME: begin
        if (lc[LC_RESET]) begin
          next_state = DRV_RESET;
        end else if (!lc[LC_RESUME]) begin
          next_state = DRV_EOP_SE0;
        end
      end
      DRV_EOP_SE0: begin
        if (lc[LC_RESET]) begin
          next_state = DRV_RESET;
        end else if (eop_cnt == EOP_SE0_LAST) begin
          next_state = DRV_EOP_J;
        end
      end
      DRV_EOP_J: begin
        if (lc[LC_RESET]) begin
          next_state = DRV_RESET;
        end else if (eop_cnt == EOP_J_LAST) begin
          next_state = DRV_IDLE;
        end
      end
    endcase
  end

  // state and eop timing counter, restarted on each change of state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state   <= DRV_IDLE;
      eop_cnt <= 8'h00;
    end else if (ce_i) begin
      state <= next_state;
      if (next_state != state) begin
        eop_cnt <= 8'h00;
      end else begin
        eop_cnt <= eop_cnt + 8'h01;
      end
    end
  end

  // host levels per state; k depends on speed, eop j always drives d- high
  always_comb begin
    host_en = 1'b1;
    host_dp = 1'b0;
    host_dm = 1'b0;
    unique case (state)
      DRV_IDLE:    host_en = 1'b0;
      DRV_RESET:   host_en = 1'b1;
      DRV_RESUME: begin
        host_dp = lc[LC_SPEED];
        host_dm = !lc[LC_SPEED];
      end
      DRV_EOP_SE0: host_en = 1'b1;
      DRV_EOP_J:   host_dm = 1'b1;
    endcase
  end

  // pin drivers: direction one overrides with the latch bit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dplus_o     <= 1'b0;
      dplus_oe_o  <= 1'b0;
      dminus_o    <= 1'b0;
      dminus_oe_o <= 1'b0;
    end else if (ce_i) begin
      dplus_oe_o  <= dir[PIN_DP] || host_en;
      dminus_oe_o <= dir[PIN_DM] || host_en;
      dplus_o     <= dir[PIN_DP] ? latch[PIN_DP] : host_dp;
      dminus_o    <= dir[PIN_DM] ? latch[PIN_DM] : host_dm;
    end
  end

  // frame start strobe, speed and frame number outputs
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sof_strobe_o   <= 1'b0;
      low_speed_o    <= 1'b0;
      frame_number_o <= RST_FRAME;
    end else if (ce_i) begin
      sof_strobe_o   <= frame_tick && (state == DRV_IDLE);
      low_speed_o    <= lc[LC_SPEED];
      frame_number_o <= frame_num;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !ce_i);

  chk_reset_se0_drive: assert property (
    state == DRV_RESET && dir[7:6] == 2'b00 |=>
      dplus_oe_o && dminus_oe_o && !dplus_o && !dminus_o)
    else $error("bus reset not driving se0");

  chk_resume_k_level: assert property (
    state == DRV_RESUME && dir[7:6] == 2'b00 |=>
      dplus_oe_o && dplus_o == $past(lc[LC_SPEED]) && dminus_o != dplus_o)
    else $error("resume not driving k");

  chk_resume_end_eop: assert property (
    state == DRV_RESUME && !lc[LC_RESUME] && !lc[LC_RESET] |=>
      state == DRV_EOP_SE0 ##1 (!dplus_o && !dminus_o) || lc[LC_RESET])
    else $error("resume end without eop");

  chk_eop_se0_len: assert property (
    state == DRV_EOP_SE0 && eop_cnt == EOP_SE0_LAST && !lc[LC_RESET] |=>
      state == DRV_EOP_J)
    else $error("eop se0 length wrong");

  chk_sof_skip_busy: assert property (
    frame_tick && state != DRV_IDLE |=> !sof_strobe_o)
    else $error("frame start sent during reset or resume");

  chk_sof_when_off: assert property (
    !lc[LC_SOF] [*2] |=> !sof_strobe_o)
    else $error("frame start while disabled");

  chk_frame_num_step: assert property (
    frame_tick && !(wr_go && (paddr_i == A_FRAME_LO || paddr_i == A_FRAME_HI))
      |=> frame_num == 16'($past(frame_num) + 16'h0001))
    else $error("frame number did not count");

  chk_flag_sticky: assert property (
    ev_flag[FL_DET] && !(wr_go && paddr_i == A_EVENT) |=> ev_flag[FL_DET])
    else $error("detach flag dropped by itself");

  chk_detect_sets: assert property (
    det_hit[FL_DET] |=> ev_flag[FL_DET] ##1 irq_detect_o || !$past(ev_en[FL_DET]))
    else $error("detach flag not set");

  chk_irq_detect: assert property (
    |(ev_flag & ev_en) |=> irq_detect_o)
    else $error("detect interrupt missing");

  chk_bus_active_set: assert property (
    obs_state != exp_state |=> ba_flag ##1 (hold_release_o || !$past(ba_en)))
    else $error("bus active flag not set");

  chk_hold_release: assert property (
    ba_flag && ba_en |=> hold_release_o && irq_bus_active_o)
    else $error("hold release missing");

  chk_gp_output: assert property (
    dir[PIN_DP] |=> dplus_oe_o && dplus_o == $past(latch[PIN_DP]))
    else $error("direction override not driving latch");

  chk_pin_readback: assert property (
    setup && paddr_i == A_LATCH && !rmw_access_i |=>
      prdata_o[7:6] == $past({line.dp, line.dm}))
    else $error("latch read did not return pins");

  cover_sof_sent:    cover property (sof_strobe_o);
  cover_eop_done:    cover property (state == DRV_EOP_J ##1 state == DRV_IDLE);
  cover_detach_irq:  cover property (irq_detect_o && ev_flag[FL_DET]);
  cover_hold_release: cover property (hold_release_o);
endmodule
`default_nettype wire

// file: verification/hbp_dev_model.sv
// usb device stand-in at the far end of the port b lines
`timescale 1ns/1ps
`default_nettype none
module hbp_dev_model (
  input  wire logic [1:0] mode_i,      // 0 detached, 1 full speed, 2 low speed
  input  wire logic       dplus_i,     // host d+ value
  input  wire logic       dplus_oe_i,  // host drives d+
  input  wire logic       dminus_i,    // host d- value
  input  wire logic       dminus_oe_i, // host drives d-
  output logic            dplus_o,     // resolved d+ level
  output logic            dminus_o     // resolved d- level
);
  // a driving host wins; else the device pull-up or the host pull-downs set the level
  assign dplus_o  = dplus_oe_i ? dplus_i : (mode_i == 2'd1);
  assign dminus_o = dminus_oe_i ? dminus_i : (mode_i == 2'd2);
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the port b line control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hbp_pkg::*;
  localparam int unsigned FC = 200; // shortened frame period
  localparam int unsigned DC = 20;  // shortened persistence count
  logic        clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0, rmw = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic        pready, pslverr, err, dp, dm, dp_o, dp_oe, dm_o, dm_oe, ls, sof;
  logic        irq_d, irq_b, hold;
  logic [15:0] fnum;
  logic [1:0]  mode = 2'd0;
  logic        ce = 1'b1;
  int          mismatches = 0, tests_run = 0, sof_cnt = 0;

  // 125 mhz clock and frame-start pulse counter
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (sof === 1'b1) sof_cnt++;

  hbp_port_ctrl #(.FRAME_COUNT(FC), .DET_COUNT(DC)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rmw_access_i(rmw),
    .dplus_pin_i(dp), .dminus_pin_i(dm), .dplus_o(dp_o), .dplus_oe_o(dp_oe),
    .dminus_o(dm_o), .dminus_oe_o(dm_oe), .low_speed_o(ls), .sof_strobe_o(sof),
    .frame_number_o(fnum), .irq_detect_o(irq_d), .irq_bus_active_o(irq_b),
    .hold_release_o(hold));
  hbp_dev_model i_dev (.mode_i(mode), .dplus_i(dp_o), .dplus_oe_i(dp_oe),
    .dminus_i(dm_o), .dminus_oe_i(dm_oe), .dplus_o(dp), .dminus_o(dm));

  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  // host pin drive as {dp_oe, dm_oe, dp, dm}
  task automatic pins(input logic [3:0] e);
    check({28'h0, dp_oe, dm_oe, dp_o, dm_o}, {28'h0, e});
  endtask

  // reset values, read-only bits, unmapped access, speed select
  task automatic t_regs();
    apb(0, A_EVENT, 0); check(rdat, 32'h0);
    apb(0, A_LINE, 0); check(rdat, 32'hf0);
    apb(1, A_TEST, 8'ha5); apb(0, A_TEST, 0); check(rdat, 32'ha5);
    apb(0, 18'h00010, 0); check({31'h0, err}, 32'h1);
    apb(1, A_LINE, 8'h08); @(posedge clk_i); check({31'h0, ls}, 32'h1);
    apb(1, A_LINE, 8'h00); @(posedge clk_i); check({31'h0, ls}, 32'h0);
    $display("registers done");
  endtask

  // bus reset and resume driving, end of resume
  task automatic t_drive();
    apb(1, A_LINE, 8'h04); repeat (50) @(posedge clk_i); pins(4'hc);
    apb(1, A_LINE, 8'h00); repeat (3) @(posedge clk_i); pins(4'h0);
    apb(1, A_LINE, 8'h02); repeat (50) @(posedge clk_i); pins(4'hd);
    apb(1, A_LINE, 8'h00); repeat (5) @(posedge clk_i); pins(4'hc);
    repeat (170) @(posedge clk_i); pins(4'hd);
    repeat (100) @(posedge clk_i); pins(4'h0);
    apb(1, A_LINE, 8'h0a); repeat (50) @(posedge clk_i); pins(4'he);
    apb(1, A_LINE, 8'h00); repeat (260) @(posedge clk_i); pins(4'h0);
    $display("line drive done");
  endtask

  // frame timer, skipped frame start, frame numbering
  task automatic t_frame();
    apb(1, A_FRAME_LO, 0); apb(1, A_FRAME_HI, 0);
    sof_cnt = 0;
    apb(1, A_LINE, 8'h01); repeat (2 * FC + 10) @(posedge clk_i);
    check(sof_cnt, 2); check({16'h0, fnum}, 32'h2);
    sof_cnt = 0;
    apb(1, A_LINE, 8'h05); repeat (FC) @(posedge clk_i);
    check(sof_cnt, 0); check({16'h0, fnum}, 32'h3);
    ce <= 1'b0; repeat (FC + 10) @(posedge clk_i); ce <= 1'b1;
    check({16'h0, fnum}, 32'h3);
    apb(1, A_LINE, 8'h00);
    $display("frame timer done");
  endtask

  // attach, sticky flags, detach, low-speed attach, masking
  task automatic t_detect();
    apb(1, A_EVENT, 8'h04); apb(1, A_ACTIVE, 8'h04);
    check({31'h0, irq_b}, 32'h0);
    mode <= 2'd1; repeat (6) @(posedge clk_i);
    check({30'h0, irq_b, hold}, 32'h3);
    repeat (DC + 10) @(posedge clk_i); apb(0, A_EVENT, 0);
    check(rdat, 32'h8c); check({31'h0, irq_d}, 32'h1);
    apb(1, A_EVENT, 8'h06); apb(0, A_EVENT, 0); check(rdat, 32'h0e);
    apb(1, A_ACTIVE, 8'h04); @(posedge clk_i); check({31'h0, irq_b}, 32'h0);
    mode <= 2'd0; repeat (DC + 10) @(posedge clk_i); apb(0, A_EVENT, 0);
    check(rdat, 32'h8e); check({31'h0, irq_b}, 32'h1);
    mode <= 2'd2; repeat (DC + 10) @(posedge clk_i); apb(0, A_EVENT, 0);
    check(rdat, 32'hae);
    apb(1, A_EVENT, 8'h00); repeat (3) @(posedge clk_i);
    check({31'h0, irq_d}, 32'h0);
    $display("detection done");
  endtask

  // pin read-back, stored latch on read-modify-write, direction override
  task automatic t_latch();
    mode <= 2'd1;
    apb(1, A_DIR, 8'h00); apb(1, A_LATCH, 8'h40); repeat (4) @(posedge clk_i);
    apb(0, A_LATCH, 0); check(rdat, 32'h80);
    rmw <= 1'b1;
    apb(0, A_LATCH, 0); check(rdat, 32'h40);
    rmw <= 1'b0;
    apb(1, A_DIR, 8'hc0); repeat (4) @(posedge clk_i); pins(4'hd);
    apb(0, A_LATCH, 0); check(rdat, 32'h40);
    apb(1, A_DIR, 8'h00);
    $display("port latch done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_drive();
    t_frame();
    t_detect();
    t_latch();
    close_out();
  end
endmodule
`default_nettype wire
